// ### rtl/dsc_decode_map.svh
// opcode values, field positions and cycle counts for the instruction decoder
`ifndef DSC_DECODE_MAP_SVH
`define DSC_DECODE_MAP_SVH

// ==========================================================================
// word layout
`define WORD_W 24
`define OPC_W 8
`define OPC_RANGE 23:16
`define NIB_RANGE 7:4
`define ZERO_OPC 8'h00
`define PROG_ADDR_W 23

// ==========================================================================
// opcode groups, selected by the upper opcode nibble
`define NIB_CTRL 4'h0
`define NIB_BRANCH 4'h3
`define NIB_LIT_MOVE 4'h2
`define NIB_LIT_FILE 4'h9
`define NIB_LIT_ARITH 4'hB
`define NIB_FILE_A 4'h7
`define NIB_FILE_B 4'hD
`define NIB_BIT_LIT 4'hA
`define NIB_BIT_IND 4'h8
`define NIB_DSP 4'hC
`define NIB_MAC 4'hF
`define BRA_UNCOND_BIT 3

// ==========================================================================
// individual opcodes with special length or timing
`define OP_CALL_IND 8'h01
`define OP_CALL_DW 8'h02
`define OP_GOTO_DW 8'h04
`define OP_JUMP_IND 8'h05
`define OP_RETURN 8'h06
`define OP_RETINT 8'h07
`define OP_DO_DW 8'h08
`define OP_TBL_RD 8'h0A
`define OP_TBL_WR 8'h0B

// ==========================================================================
// instruction cycle counts
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3

// ==========================================================================
// operand field positions
`define WB_RANGE 19:16
`define WS_RANGE 3:0
`define WS_MODE_RANGE 6:4
`define WD_RANGE 10:7
`define WD_MODE_RANGE 13:11
`define BYTE_BIT 14
`define FILE_RANGE 12:0
`define FILE_DST_BIT 13
`define BIT_NUM_RANGE 15:12
`define BIT_FILE_BIT 11
`define BFILE_RANGE 10:0
`define LIT16_RANGE 15:0
`define LIT8_RANGE 19:12
`define LFILE_RANGE 11:0
`define LARITH_SEP_BIT 15
`define LIT10_RANGE 14:5
`define ACC_BIT 15
`define MUL_RANGE 14:12
`define XPF_RANGE 11:8
`define YPF_RANGE 7:4
`define XD_RANGE 3:2
`define YD_RANGE 1:0
`define AWB_RANGE 17:16
`define SHIFT_REG_BIT 14
`define SHIFT_LIT_RANGE 12:7
`define PA_LO_RANGE 15:0
`define PA_HI_RANGE 6:0
`define TBL_MODE_RANGE 15:14

`endif

// ### rtl/dsc_decode_pkg.sv
// types shared by the instruction decoder files
`include "dsc_decode_map.svh"
package dsc_decode_pkg;

  // ========================================================================
  // categories and operand forms
  typedef enum logic [2:0] {
    cat_word_byte,
    cat_bit,
    cat_literal,
    cat_dsp,
    cat_control
  } category_type;

  typedef enum logic [3:0] {
    form_work_reg_zero,
    form_file,
    form_bit_lit,
    form_bit_ind,
    form_lit_move,
    form_lit_file,
    form_lit_arith,
    form_mac,
    form_dsp_other,
    form_ctrl
  } form_type;

  function automatic category_type category_of(input form_type f);
    case (f)
      form_work_reg_zero, form_file: return cat_word_byte;
      form_bit_lit, form_bit_ind: return cat_bit;
      form_lit_move, form_lit_file, form_lit_arith: return cat_literal;
      form_mac, form_dsp_other: return cat_dsp;
      default: return cat_control;
    endcase
  endfunction

  // ========================================================================
  // opcode classification
  function automatic form_type form_of(input logic [`OPC_W-1:0] op);
    case (op[`NIB_RANGE])
      `NIB_CTRL, `NIB_BRANCH: return form_ctrl;
      `NIB_LIT_MOVE: return form_lit_move;
      `NIB_LIT_FILE: return form_lit_file;
      `NIB_LIT_ARITH: return form_lit_arith;
      `NIB_FILE_A, `NIB_FILE_B: return form_file;
      `NIB_BIT_LIT: return form_bit_lit;
      `NIB_BIT_IND: return form_bit_ind;
      `NIB_DSP: return form_dsp_other;
      `NIB_MAC: return form_mac;
      default: return form_work_reg_zero;
    endcase
  endfunction

  function automatic logic is_double(input logic [`OPC_W-1:0] op);
    return (op == `OP_CALL_DW) || (op == `OP_GOTO_DW) || (op == `OP_DO_DW); // [RULE2]
  endfunction

  function automatic logic is_cond(input logic [`OPC_W-1:0] op);
    return (op[`NIB_RANGE] == `NIB_BRANCH) && !op[`BRA_UNCOND_BIT];
  endfunction

  function automatic logic [1:0] base_cycles(input logic [`OPC_W-1:0] op);
    case (op)
      `OP_CALL_IND, `OP_JUMP_IND, `OP_TBL_RD, `OP_TBL_WR: return `CYC_TWO; // [RULE16]
      `OP_RETURN, `OP_RETINT: return `CYC_THREE; // [RULE16]
      default:
      begin
        if (op[`NIB_RANGE] == `NIB_BRANCH && op[`BRA_UNCOND_BIT])
        begin
          return `CYC_TWO; // [RULE16]
        end
        return `CYC_ONE; // [RULE6]
      end
    endcase
  endfunction

endpackage

// ### rtl/dsc_instruction_format_decoder.sv
// instruction format decoder: word length, category, operands and cycle count
`timescale 1ns/1ps
`include "dsc_decode_map.svh"
// Behaviour
// RULE1 - single word is 24 bits: 8-bit opcode on top, operands below
// RULE2 - exactly three opcodes span two consecutive words, 48 bits in all
// RULE3 - second word of a double-word instruction has its top eight bits zero
// RULE4 - a second word decoded alone acts as a no-operation
// RULE5 - double-word instructions complete in two instruction cycles
// RULE6 - single word takes one cycle, one more when condition true or PC changes; conditional branches take two cycles here, three when true
// RULE7 - every instruction falls into one of five categories
// RULE8 - working-register word/byte ops yield base, source and destination registers
// RULE9 - file-register ops yield a file address and file-or-work-register-zero select
// RULE10 - bit ops yield a target and a bit number, literal or from base register
// RULE11 - literal moves yield a literal and a working or file register target
// RULE12 - literal arithmetic yields base, literal and an optional separate destination
// RULE13 - multiply-accumulate ops yield accumulator, multiplier pair, prefetches, write-back
// RULE14 - other signal ops yield accumulator, operand and a register or literal shift
// RULE15 - control ops yield a program address and the table access mode
// RULE16 - branches, indirect jumps, table ops and returns take two or three cycles
module dsc_instruction_format_decoder
  import dsc_decode_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic fetch_valid,
  input wire logic [`WORD_W-1:0] fetch_word,
  input wire logic cond_true,
  output logic fetch_ready,
  output logic dec_valid,
  output logic [`OPC_W-1:0] dec_opcode,
  output category_type dec_category,
  output logic dec_double,
  output logic dec_nop,
  output logic dec_cond,
  output logic dec_second_err,
  output logic [1:0] dec_cycles,
  output logic [3:0] source_work_reg,
  output logic [2:0] source_mode,
  output logic [3:0] base_work_reg,
  output logic [3:0] dest_work_reg,
  output logic [2:0] dest_mode,
  output logic byte_op,
  output logic [12:0] file_addr,
  output logic dest_is_work_reg_zero,
  output logic [3:0] bit_num,
  output logic bit_indirect,
  output logic bit_on_file,
  output logic [15:0] literal,
  output logic acc_b,
  output logic [2:0] mul_pair,
  output logic [3:0] x_prefetch,
  output logic [3:0] y_prefetch,
  output logic [1:0] x_dest,
  output logic [1:0] y_dest,
  output logic [1:0] acc_write_back,
  output logic shift_from_reg,
  output logic [3:0] shift_amount_reg,
  output logic [`PROG_ADDR_W-1:0] prog_addr,
  output logic [1:0] table_mode
);

  // ========================================================================
  // sequencer states
  typedef enum {st_idle, st_second, st_hold, st_cond} state_type;

  // ========================================================================
  // fetch handshake and sequencing
  state_type state_r;
  state_type state_nxt;
  logic [1:0] hold_r;
  logic [1:0] hold_nxt;
  logic [`WORD_W-1:0] first_word_r;
  logic take;
  logic [`OPC_W-1:0] opc;
  logic emit_first;
  logic emit_second;
  logic [`WORD_W-1:0] split_first;
  logic [`WORD_W-1:0] split_second;
  form_type split_form;

  assign take = fetch_valid && fetch_ready;
  assign opc = fetch_word[`OPC_RANGE]; // [RULE1]
  assign emit_first = take && (state_r == st_idle) && !is_double(opc);
  assign emit_second = take && (state_r == st_second);
  assign split_first = emit_second ? first_word_r : fetch_word;
  assign split_second = emit_second ? fetch_word : '0;
  assign split_form = form_of(split_first[`OPC_RANGE]);

  always_comb
  begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    case (state_r)
      st_idle:
      begin
        if (take && is_double(opc))
        begin
          state_nxt = st_second; // [RULE2]
        end
        else if (take && base_cycles(opc) != `CYC_ONE)
        begin
          state_nxt = st_hold; // [RULE16]
          hold_nxt = base_cycles(opc) - `CYC_ONE;
        end
        else if (take && is_cond(opc))
        begin
          state_nxt = st_cond;
        end
      end
      st_second:
      begin
        // both fetch cycles are the two cycles of the instruction
        if (take)
        begin
          state_nxt = st_idle; // [RULE5]
        end
      end
      st_hold:
      begin
        if (hold_r == `CYC_ONE)
        begin
          state_nxt = st_idle;
        end
        else
        begin
          hold_nxt = hold_r - `CYC_ONE;
        end
      end
      st_cond:
      begin
        // the datapath answers the test in this cycle; fetch stays stalled
        if (cond_true)
        begin
          state_nxt = st_hold; // [RULE6]
          hold_nxt = `CYC_ONE;
        end
        else
        begin
          state_nxt = st_idle;
        end
      end
      default:
      begin
        state_nxt = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= st_idle;
      hold_r <= '0;
      fetch_ready <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      fetch_ready <= (state_nxt == st_idle) || (state_nxt == st_second);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      first_word_r <= '0;
    end
    else if (take && state_r == st_idle)
    begin
      first_word_r <= fetch_word;
    end
  end

  // ========================================================================
  // decode result
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dec_valid <= 1'b0;
      dec_opcode <= '0;
      dec_category <= cat_control;
      dec_double <= 1'b0;
      dec_nop <= 1'b0;
      dec_cond <= 1'b0;
      dec_second_err <= 1'b0;
      dec_cycles <= `CYC_ONE;
    end
    else
    begin
      dec_valid <= emit_first || emit_second;
      if (emit_first || emit_second)
      begin
        dec_opcode <= split_first[`OPC_RANGE]; // [RULE1]
        dec_category <= category_of(split_form); // [RULE7]
        dec_double <= emit_second;
        dec_nop <= emit_first && (opc == `ZERO_OPC); // [RULE4]
        dec_cond <= emit_first && is_cond(opc);
        // a non-zero top byte in a second word is flagged, fields still decode
        dec_second_err <= emit_second && (fetch_word[`OPC_RANGE] != `ZERO_OPC); // [RULE3]
        dec_cycles <= emit_second ? `CYC_TWO : base_cycles(opc); // [RULE5] [RULE6]
      end
    end
  end

  operand_split fields (
    .clk(clk),
    .reset(reset),
    .load(emit_first || emit_second),
    .clear(emit_first && (opc == `ZERO_OPC)), // [RULE4]
    .form(split_form),
    .first_word(split_first),
    .second_word(split_second),
    .source_work_reg(source_work_reg),
    .source_mode(source_mode),
    .base_work_reg(base_work_reg),
    .dest_work_reg(dest_work_reg),
    .dest_mode(dest_mode),
    .byte_op(byte_op),
    .file_addr(file_addr),
    .dest_is_work_reg_zero(dest_is_work_reg_zero),
    .bit_num(bit_num),
    .bit_indirect(bit_indirect),
    .bit_on_file(bit_on_file),
    .literal(literal),
    .acc_b(acc_b),
    .mul_pair(mul_pair),
    .x_prefetch(x_prefetch),
    .y_prefetch(y_prefetch),
    .x_dest(x_dest),
    .y_dest(y_dest),
    .acc_write_back(acc_write_back),
    .shift_from_reg(shift_from_reg),
    .shift_amount_reg(shift_amount_reg),
    .prog_addr(prog_addr),
    .table_mode(table_mode)
  );

  // ========================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence stall_one;
    !fetch_ready ##1 fetch_ready;
  endsequence

  sequence stall_two;
    !fetch_ready ##1 !fetch_ready ##1 fetch_ready;
  endsequence

  chk_double_second: assert property ((take && state_r == st_idle && is_double(opc)) |=> // [RULE2]
    (state_r == st_second && fetch_ready && !dec_valid))
    else $error("double-word first word did not wait for second word");
  chk_double_cycles: assert property (emit_second |=> // [RULE5]
    (dec_valid && dec_double && dec_cycles == `CYC_TWO && fetch_ready))
    else $error("double-word instruction not completed in two cycles");
  chk_second_zero: assert property (emit_second |=> // [RULE3]
    (dec_second_err == ($past(fetch_word[`OPC_RANGE]) != `ZERO_OPC)))
    else $error("second word top byte check wrong");
  chk_lone_nop: assert property ((emit_first && opc == `ZERO_OPC) |=> // [RULE4]
    (dec_valid && dec_nop && literal == '0 && file_addr == '0 && prog_addr == '0))
    else $error("lone second word not decoded as no-operation");
  chk_single_one: assert property ((emit_first && base_cycles(opc) == `CYC_ONE // [RULE6]
    && !is_cond(opc)) |=> (dec_valid && fetch_ready && dec_cycles == `CYC_ONE))
    else $error("plain single-word instruction did not take one cycle");
  chk_cond_extra: assert property ((state_r == st_cond && cond_true) |=> stall_one) // [RULE6]
    else $error("true condition did not add one cycle");
  chk_return_three: assert property ((emit_first && (opc == `OP_RETURN // [RULE16]
    || opc == `OP_RETINT)) |=> (dec_cycles == `CYC_THREE) and stall_two)
    else $error("return did not take three cycles");
  chk_branch_two: assert property ((emit_first && base_cycles(opc) == `CYC_TWO) // [RULE16]
    |=> stall_one)
    else $error("two-cycle instruction stall wrong");
  chk_category_match: assert property (dec_valid |-> // [RULE7]
    (dec_category == category_of(form_of(dec_opcode))))
    else $error("category does not follow opcode");
  chk_file_dest: assert property ((emit_first && form_of(opc) == form_file) |=> // [RULE9]
    (dest_is_work_reg_zero == !$past(fetch_word[`FILE_DST_BIT])))
    else $error("file register destination select wrong");

endmodule

// ### rtl/operand_split.sv
// operand field registers, loaded from one or two program words
`timescale 1ns/1ps
`include "dsc_decode_map.svh"
module operand_split
  import dsc_decode_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic clear,
  input form_type form,
  input wire logic [`WORD_W-1:0] first_word,
  input wire logic [`WORD_W-1:0] second_word,
  output logic [3:0] source_work_reg,
  output logic [2:0] source_mode,
  output logic [3:0] base_work_reg,
  output logic [3:0] dest_work_reg,
  output logic [2:0] dest_mode,
  output logic byte_op,
  output logic [12:0] file_addr,
  output logic dest_is_work_reg_zero,
  output logic [3:0] bit_num,
  output logic bit_indirect,
  output logic bit_on_file,
  output logic [15:0] literal,
  output logic acc_b,
  output logic [2:0] mul_pair,
  output logic [3:0] x_prefetch,
  output logic [3:0] y_prefetch,
  output logic [1:0] x_dest,
  output logic [1:0] y_dest,
  output logic [1:0] acc_write_back,
  output logic shift_from_reg,
  output logic [3:0] shift_amount_reg,
  output logic [`PROG_ADDR_W-1:0] prog_addr,
  output logic [1:0] table_mode
);

  // ========================================================================
  // field capture; every field not used by the form reads as zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      source_work_reg <= '0;
      source_mode <= '0;
      base_work_reg <= '0;
      dest_work_reg <= '0;
      dest_mode <= '0;
      byte_op <= 1'b0;
      file_addr <= '0;
      dest_is_work_reg_zero <= 1'b0;
      bit_num <= '0;
      bit_indirect <= 1'b0;
      bit_on_file <= 1'b0;
      literal <= '0;
      acc_b <= 1'b0;
      mul_pair <= '0;
      x_prefetch <= '0;
      y_prefetch <= '0;
      x_dest <= '0;
      y_dest <= '0;
      acc_write_back <= '0;
      shift_from_reg <= 1'b0;
      shift_amount_reg <= '0;
      prog_addr <= '0;
      table_mode <= '0;
    end
    else if (load)
    begin
      source_work_reg <= '0;
      source_mode <= '0;
      base_work_reg <= '0;
      dest_work_reg <= '0;
      dest_mode <= '0;
      byte_op <= 1'b0;
      file_addr <= '0;
      dest_is_work_reg_zero <= 1'b0;
      bit_num <= '0;
      bit_indirect <= 1'b0;
      bit_on_file <= 1'b0;
      literal <= '0;
      acc_b <= 1'b0;
      mul_pair <= '0;
      x_prefetch <= '0;
      y_prefetch <= '0;
      x_dest <= '0;
      y_dest <= '0;
      acc_write_back <= '0;
      shift_from_reg <= 1'b0;
      shift_amount_reg <= '0;
      prog_addr <= '0;
      table_mode <= '0;
      case (form)
        form_work_reg_zero:
        begin
          base_work_reg <= first_word[`WB_RANGE]; // [RULE8]
          source_work_reg <= first_word[`WS_RANGE]; // [RULE8]
          source_mode <= first_word[`WS_MODE_RANGE];
          dest_work_reg <= first_word[`WD_RANGE]; // [RULE8]
          dest_mode <= first_word[`WD_MODE_RANGE];
          byte_op <= first_word[`BYTE_BIT];
        end
        form_file:
        begin
          file_addr <= first_word[`FILE_RANGE]; // [RULE9]
          dest_is_work_reg_zero <= ~first_word[`FILE_DST_BIT]; // [RULE9]
          byte_op <= first_word[`BYTE_BIT];
        end
        form_bit_lit, form_bit_ind:
        begin
          bit_on_file <= first_word[`BIT_FILE_BIT]; // [RULE10]
          if (first_word[`BIT_FILE_BIT])
          begin
            file_addr <= {2'b00, first_word[`BFILE_RANGE]};
          end
          else
          begin
            source_work_reg <= first_word[`WS_RANGE];
            source_mode <= first_word[`WS_MODE_RANGE];
          end
          if (form == form_bit_ind)
          begin
            bit_indirect <= 1'b1; // [RULE10]
            base_work_reg <= first_word[`WB_RANGE];
          end
          else
          begin
            bit_num <= first_word[`BIT_NUM_RANGE]; // [RULE10]
          end
        end
        form_lit_move:
        begin
          literal <= first_word[`LIT16_RANGE]; // [RULE11]
          dest_work_reg <= first_word[`WB_RANGE]; // [RULE11]
        end
        form_lit_file:
        begin
          literal <= {8'h00, first_word[`LIT8_RANGE]}; // [RULE11]
          file_addr <= {1'b0, first_word[`LFILE_RANGE]}; // [RULE11]
        end
        form_lit_arith:
        begin
          base_work_reg <= first_word[`WB_RANGE]; // [RULE12]
          literal <= {6'h00, first_word[`LIT10_RANGE]}; // [RULE12]
          // without a separate destination the result goes back to the base register
          dest_work_reg <= first_word[`LARITH_SEP_BIT] ? first_word[`WS_RANGE]
                                                       : first_word[`WB_RANGE]; // [RULE12]
        end
        form_mac:
        begin
          acc_b <= first_word[`ACC_BIT]; // [RULE13]
          mul_pair <= first_word[`MUL_RANGE]; // [RULE13]
          x_prefetch <= first_word[`XPF_RANGE]; // [RULE13]
          y_prefetch <= first_word[`YPF_RANGE];
          x_dest <= first_word[`XD_RANGE];
          y_dest <= first_word[`YD_RANGE];
          acc_write_back <= first_word[`AWB_RANGE]; // [RULE13]
        end
        form_dsp_other:
        begin
          acc_b <= first_word[`ACC_BIT]; // [RULE14]
          source_work_reg <= first_word[`WS_RANGE]; // [RULE14]
          source_mode <= first_word[`WS_MODE_RANGE];
          shift_from_reg <= first_word[`SHIFT_REG_BIT]; // [RULE14]
          if (first_word[`SHIFT_REG_BIT])
          begin
            shift_amount_reg <= first_word[`WD_RANGE];
          end
          else
          begin
            literal <= {10'h000, first_word[`SHIFT_LIT_RANGE]};
          end
        end
        default:
        begin
          // a lone second word leaves every operand at zero: nothing to act on
          if (!clear) // [RULE4]
          begin
            prog_addr <= {second_word[`PA_HI_RANGE], first_word[`PA_LO_RANGE]}; // [RULE15]
            source_work_reg <= first_word[`WS_RANGE];
          end
          if (first_word[`OPC_RANGE] == `OP_TBL_RD || first_word[`OPC_RANGE] == `OP_TBL_WR)
          begin
            table_mode <= first_word[`TBL_MODE_RANGE]; // [RULE15]
          end
        end
      endcase
    end
  end

endmodule

// ### verif/dsc_instruction_format_decoder_test.sv
// self-checking bench for the instruction format decoder
`timescale 1ns/1ps
`include "dsc_decode_map.svh"
module dsc_instruction_format_decoder_test
  import dsc_decode_pkg::*;
;
  logic clk, reset, cond_true, slow, fetch_valid, fetch_ready, run;
  logic [23:0] fetch_word, f, s, w;
  logic [23:0] fq[$], sq[$];
  logic dec_valid, dec_double, dec_nop, dec_cond, dec_second_err, dest_is_work_reg_zero, acc_b;
  logic byte_op, bit_indirect, bit_on_file, shift_from_reg;
  logic [3:0] source_work_reg, base_work_reg, dest_work_reg, bit_num;
  logic [12:0] file_addr;
  logic [2:0] mul_pair;
  logic [1:0] table_mode;
  logic [7:0] dec_opcode;
  logic [1:0] dec_cycles;
  logic [15:0] literal;
  logic [22:0] prog_addr;
  category_type dec_category;
  integer seed, num_errors, n_compared, cnt, want;
  logic [7:0] corner [16] = '{8'h00, 8'h06, 8'h07, 8'h01, 8'h05, 8'h0A, 8'h0B, 8'h38, 8'h30,
    8'h02, 8'h04, 8'h08, 8'h20, 8'hF0, 8'h70, 8'hD0};

  dsc_instruction_format_decoder dsc_instruction_format_decoder_inst (.clk(clk), .reset(reset),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .cond_true(cond_true),
    .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
    .dec_category(dec_category), .dec_double(dec_double), .dec_nop(dec_nop),
    .dec_cond(dec_cond), .dec_second_err(dec_second_err), .dec_cycles(dec_cycles),
    .source_work_reg(source_work_reg), .source_mode(), .base_work_reg(base_work_reg),
    .dest_work_reg(dest_work_reg), .dest_mode(), .byte_op(byte_op), .file_addr(file_addr),
    .dest_is_work_reg_zero(dest_is_work_reg_zero), .bit_num(bit_num),
    .bit_indirect(bit_indirect), .bit_on_file(bit_on_file), .literal(literal), .acc_b(acc_b),
    .mul_pair(mul_pair), .x_prefetch(), .y_prefetch(), .x_dest(), .y_dest(),
    .acc_write_back(), .shift_from_reg(shift_from_reg), .shift_amount_reg(),
    .prog_addr(prog_addr), .table_mode(table_mode));

  fetch_model fetch_model_inst (.clk(clk), .reset(reset), .slow(slow),
    .fetch_ready(fetch_ready), .fetch_valid(fetch_valid), .fetch_word(fetch_word));

  // =======================================================================
  // expectations
  function automatic logic dbl(input logic [7:0] op);
    return op == `OP_CALL_DW || op == `OP_GOTO_DW || op == `OP_DO_DW;
  endfunction

  function automatic category_type exp_cat(input logic [7:0] op);
    case (op[7:4])
      4'h0, 4'h3: return cat_control;
      4'h2, 4'h9, 4'hB: return cat_literal;
      4'h8, 4'hA: return cat_bit;
      4'hC, 4'hF: return cat_dsp;
      default: return cat_word_byte;
    endcase
  endfunction

  function automatic logic [1:0] exp_cyc(input logic [7:0] op);
    case (op)
      `OP_RETURN, `OP_RETINT: return 2'h3;
      `OP_CALL_IND, `OP_CALL_DW, `OP_GOTO_DW, `OP_JUMP_IND, `OP_DO_DW, `OP_TBL_RD, `OP_TBL_WR:
        return 2'h2;
      default: return op[7:3] == 5'h07 ? 2'h2 : 2'h1;
    endcase
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task send(input logic [23:0] first, input logic [23:0] second);
    fetch_model_inst.push(first);
    fq.push_back(first);
    sq.push_back(dbl(first[23:16]) ? second : 24'h000000);
    if (dbl(first[23:16]))
      fetch_model_inst.push(second);
  endtask

  task stop_test;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // =======================================================================
  // monitor: decoded fields and stall length after each answer
  always @(negedge clk)
  begin
    if (!reset && dec_valid === 1'b1)
    begin
      f = fq.pop_front();
      s = sq.pop_front();
      check(dec_opcode, f[23:16]);
      check(dec_nop, f[23:16] == 8'h00);
      check(dec_category, exp_cat(f[23:16]));
      check(dec_double, dbl(f[23:16]));
      check(dec_cycles, exp_cyc(f[23:16]));
      check(dec_cond, f[23:19] == 5'h06);
      check(dec_second_err, s[23:16] != 8'h00);
      if (dbl(f[23:16]))
        check(prog_addr, {s[6:0], f[15:0]});
      if (f[23:20] == `NIB_LIT_MOVE)
        check(literal, f[15:0]);
      if (f[23:20] == `NIB_MAC || f[23:20] == `NIB_DSP)
        check(acc_b, f[15]);
      if (f[23:20] == `NIB_FILE_A || f[23:20] == `NIB_FILE_B)
      begin
        check(dest_is_work_reg_zero, !f[13]);
        check(file_addr, f[12:0]);
      end
      if (f[23:20] inside {4'h1, 4'h4, 4'h5, 4'h6, 4'hE})
      begin
        check(base_work_reg, f[19:16]);
        check(source_work_reg, f[3:0]);
        check(dest_work_reg, f[10:7]);
        check(byte_op, f[14]);
      end
      if (f[23:20] == `NIB_BIT_LIT || f[23:20] == `NIB_BIT_IND)
      begin
        check(bit_on_file, f[11]);
        check(bit_indirect, f[23:20] == `NIB_BIT_IND);
        check(bit_num, f[23:20] == `NIB_BIT_LIT ? f[15:12] : 4'h0);
      end
      if (f[23:20] == `NIB_LIT_FILE)
        check(file_addr, {1'b0, f[11:0]});
      if (f[23:20] == `NIB_LIT_ARITH)
        check(dest_work_reg, f[15] ? f[3:0] : f[19:16]);
      if (f[23:20] == `NIB_MAC)
        check(mul_pair, f[14:12]);
      if (f[23:20] == `NIB_DSP)
        check(shift_from_reg, f[14]);
      if (f[23:16] == `OP_TBL_RD || f[23:16] == `OP_TBL_WR)
        check(table_mode, f[15:14]);
      run = 1'b1;
      cnt = 0;
      want = f[23:19] == 5'h06 ? 1 + cond_true : dbl(f[23:16]) ? 0 : exp_cyc(f[23:16]) - 1;
    end
    if (run && fetch_ready === 1'b1)
    begin
      check(cnt, want);
      run = 1'b0;
    end
    else if (run)
      cnt++;
  end

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
    #1 cond_true = 1'($random(seed));

  initial
  begin
    #(25 * 40000);
    num_errors++;
    stop_test;
  end

  initial
  begin
    seed = 60;
    reset = 1'b1;
    cond_true = 1'b0;
    slow = 1'b0;
    run = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    foreach (corner[i])
      send({corner[i], 16'h8A5C}, 24'h00137F);
    // second word with a non-zero top byte still pairs, but is flagged
    send({`OP_GOTO_DW, 16'h1234}, 24'h01ABCD);
    for (int i = 0; i < 400; i++)
    begin
      while (fq.size() > 4)
        @(posedge clk);
      if (i == 200)
        slow = 1'b1;
      w = 24'($random(seed));
      f = 24'($random(seed));
      send(w, {8'h00, f[15:0]});
    end
    for (int k = 0; k < 2000 && fq.size() != 0; k++)
      @(posedge clk);
    check(fq.size(), 0);
    stop_test;
  end
endmodule

// ### verif/fetch_model.sv
// program memory fetch model feeding the decoder
`timescale 1ns/1ps
`include "dsc_decode_map.svh"
module fetch_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [`WORD_W-1:0] fetch_word
);
  logic [`WORD_W-1:0] words[$];
  logic took;

  task push(input logic [`WORD_W-1:0] w);
    words.push_back(w);
  endtask

  initial
  begin
    fetch_valid = 1'b0;
    fetch_word = 24'h5A5A5A;
  end

  // =======================================================================
  // offer words in order, held until taken
  always @(posedge clk)
  begin
    took = fetch_valid && fetch_ready && !reset;
    if (took)
      words.delete(0);
    #1;
    // a released word must not look like a fresh copy of itself
    if (took)
      fetch_word = ~fetch_word;
    // slow mode leaves one dead cycle after every word
    fetch_valid = words.size() != 0 && !(took && slow);
    if (fetch_valid)
      fetch_word = words[0];
  end
endmodule
